// *** tb/jtid_host.sv ***
// behavioural test controller on the far side of the four-pin port
`timescale 1ns/1ns
module jtid_host (
   input wire logic core_clk, // bench clock, paces tck
   output logic tck, // test clock, still between frames
   output logic tms, // mode select
   output logic tdi, // serial data to the port
   input wire logic tdo, // serial data from the port
   input wire logic tdo_oe, // port drives tdo
   output logic obs_valid, // one-cycle strobe per shifted bit
   output logic [1:0] obs // tdo_oe and tdo seen while shifting
);
   // four pins only: no test reset is ever driven
   initial begin
      tck = 1'h0;
      tms = 1'h1;
      tdi = 1'h1;
      obs_valid = 1'h0;
      obs = 2'h0;
   end
   // tck low 4 cycles, high 4; tms/tdi move only while tck is low
   task automatic step(input logic m, input logic d, input logic s);
      @(posedge core_clk);
      tms <= m;
      tdi <= d;
      repeat (3) @(posedge core_clk);
      tck <= 1'h1;
      // sample late in the high phase, tdo stands until the next fall
      repeat (3) @(posedge core_clk);
      obs <= {tdo_oe, tdo};
      obs_valid <= s;
      @(posedge core_clk);
      tck <= 1'h0;
      obs_valid <= 1'h0;
   endtask
   // from idle through one scan and back; idle tdi sits at its pull-up
   task automatic scan(input logic ir, input int n, input logic [63:0] din);
      step(1'h1, 1'h1, 1'h0);
      if (ir)
         step(1'h1, 1'h1, 1'h0);
      step(1'h0, 1'h1, 1'h0);
      step(1'h0, 1'h1, 1'h0);
      for (int i = 0; i < n; i++)
         step(i == n - 1, din[i], 1'h1);
      step(1'h1, 1'h1, 1'h0);
      step(1'h0, 1'h1, 1'h0);
   endtask
endmodule

// *** tb/jtid_tap_top_bench.sv ***
// self-checking bench for the test access port
`timescale 1ns/1ns
module jtid_tap_top_bench import jtid_pkg::*;;
   // identity fields are arbitrary neutral values
   localparam logic [31:0] ID_EXP = {4'h1, 7'h2a, 9'h033, 11'h155, 1'h1};
   localparam logic [5:0] BYP_OPS [5] = '{OP_BYPASS, OP_HIGHZ, 6'h3e,
      6'h06, OP_USER_ONE};
   logic core_clk, rst, tck, tms, tdi, tdo, tdo_oe, obs_valid, cfg_done;
   logic wr_valid, rd_valid, rd_ready, scs, utdo1, utdo2;
   logic [1:0] obs, only_in;
   logic [3:0] pad_in, pad_out, pad_oe, core_out, core_oe, status;
   logic [5:0] core_in;
   logic [31:0] ucode;
   logic [63:0] wr_data, rd_data, w, v;
   logic [63:0] wr_q[$], rd_w[4];
   logic exp_q[$];
   logic [2:0] ctl_q[$];
   jtid_user_type user;
   jtid_ctl_type ctl;
   int err_count = 0;
   int samples_checked = 0;

   jtid_host i_host (.core_clk(core_clk), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdo_oe(tdo_oe), .obs_valid(obs_valid), .obs(obs));
   jtid_tap_top #(.ID_REVISION(4'h1), .ID_FAMILY(7'h2a), .ID_SIZE(9'h033),
      .ID_COMPANY(11'h155)) i_dut (.core_clk(core_clk), .rst(rst),
      .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .only_in(only_in), .core_out(core_out), .core_oe(core_oe),
      .core_in(core_in), .config_done(cfg_done),
      .startup_clock_select(scs), .device_status(status),
      .usercode(ucode), .user(user), .user_tdo_one(utdo1),
      .user_tdo_two(utdo2), .ctl(ctl), .cfg_wr_valid(wr_valid),
      .cfg_wr_data(wr_data), .cfg_rd_valid(rd_valid),
      .cfg_rd_ready(rd_ready), .cfg_rd_data(rd_data));

   initial begin
      core_clk = 1'h0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic end_of_test();
      $display("errors %0d checks %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk_bit(input logic [1:0] got, input logic e);
      samples_checked++;
      if (got !== {1'h1, e}) begin
         err_count++;
         $display("ERROR %0t tdo_oe,tdo %b expected 1%b", $time, got, e);
      end
   endtask
   task automatic chk_word(input logic [63:0] got, input logic [63:0] e);
      samples_checked++;
      if (got !== e) begin
         err_count++;
         $display("ERROR %0t value %h expected %h", $time, got, e);
      end
   endtask
   task automatic dr_scan(input int n, input logic [63:0] e, din);
      for (int i = 0; i < n; i++)
         exp_q.push_back(e[i]);
      i_host.scan(1'h0, n, din);
   endtask
   task automatic ir_load(input logic [5:0] op);
      for (int i = 0; i < 6; i++)
         exp_q.push_back(i < 2 ? i == 0 : status[i-2]);
      i_host.scan(1'h1, 6, 64'(op));
   endtask

   // results are matched in arrival order against the driver's notes
   always @(posedge core_clk) begin
      if (obs_valid)
         chk_bit(obs, exp_q.pop_front());
      if (wr_valid !== 1'h0)
         chk_word(wr_data, wr_q.pop_front());
      if (ctl !== 3'h0)
         chk_word(64'(ctl), 64'(ctl_q.pop_front()));
   end

   initial begin
      #100000;
      err_count++;
      end_of_test();
   end

   initial begin
      {rst, cfg_done, rd_valid, rd_data} = {3'h4, 64'h0};
      {pad_in, only_in, core_out, core_oe, status, ucode} = 50'h0;
      {scs, utdo1, utdo2} = 3'h4;
      void'($urandom(32'ha02254b3));
      repeat (10) @(posedge core_clk);
      rst <= 1'h0;
      {pad_in, only_in, core_out, core_oe, status, utdo1, utdo2} <=
         20'($urandom);
      ucode <= $urandom;
      i_host.step(1'h0, 1'h1, 1'h0);
      dr_scan(32, 64'(ID_EXP), 64'h0);
      chk_word(64'(pad_oe), 64'(core_oe));
      chk_word(64'(pad_out), 64'(core_out));
      chk_word(64'(core_in), 64'({only_in, pad_in}));
      foreach (BYP_OPS[k]) begin
         ir_load(BYP_OPS[k]);
         w = {$urandom, $urandom};
         dr_scan(8, {w[62:0], 1'h0}, w);
         if (BYP_OPS[k] == OP_HIGHZ)
            chk_word(64'(pad_oe), 64'h0);
      end
      repeat (5) i_host.step(1'h1, 1'h1, 1'h0);
      chk_word(64'(user.reset), 64'h1);
      i_host.step(1'h0, 1'h1, 1'h0);
      dr_scan(32, 64'(ID_EXP), 64'h0);
      ir_load(OP_USERCODE);
      dr_scan(32, 64'(ucode), 64'h0);
      ir_load(OP_CFG_IN);
      w = {$urandom, $urandom};
      wr_q.push_back(w);
      dr_scan(64, 64'h0, w);
      for (int i = 0; i < 4; i++) begin
         rd_w[i] = {$urandom, $urandom};
         rd_valid <= 1'h1;
         rd_data <= rd_w[i];
         do @(posedge core_clk); while (rd_ready !== 1'h1);
      end
      rd_valid <= 1'h0;
      repeat (2) @(posedge core_clk);
      chk_word(64'(rd_ready), 64'h0); // full buffer refuses
      ir_load(OP_CFG_OUT);
      for (int i = 0; i < 5; i++)
         dr_scan(64, i < 4 ? rd_w[i] : 64'h0, 64'h0);
      chk_word(64'(rd_ready), 64'h1); // drained buffer takes again
      cfg_done <= 1'h1; // user registers only once configured
      ir_load(OP_USER_ONE);
      chk_word(64'(user.sel_one), 64'h1);
      dr_scan(8, {64{utdo1}}, 64'h0);
      ir_load(OP_USER_TWO);
      chk_word(64'(user.sel_two), 64'h1);
      dr_scan(8, {64{utdo2}}, 64'h0);
      ir_load(OP_SAMPLE);
      w = 64'(only_in) << 12;
      for (int i = 0; i < 4; i++)
         w[3*i +: 3] = {pad_in[i], core_out[i], core_oe[i]};
      v = 64'($urandom & 32'h3fff);
      dr_scan(14, w, v);
      ir_load(OP_EXTEST);
      w = 64'(v[13:12]) << 4;
      for (int i = 0; i < 4; i++) begin
         w[i] = v[3*i+2];
         chk_word(64'(pad_out[i]), 64'(v[3*i+1]));
         chk_word(64'(pad_oe[i]), 64'(v[3*i]));
      end
      ir_load(OP_INTEST);
      chk_word(64'(core_in), w);
      // every tck rise spent in idle under a sequencer opcode, with startup_clock_select high, is one pulse
      ir_load(OP_STARTUP);
      ctl_q.push_back(3'h4);
      i_host.step(1'h0, 1'h1, 1'h0);
      scs <= 1'h0;
      i_host.step(1'h0, 1'h1, 1'h0);
      ir_load(OP_SHUTDOWN);
      scs <= 1'h1;
      repeat (2) ctl_q.push_back(3'h2);
      i_host.step(1'h0, 1'h1, 1'h0);
      ctl_q.push_back(3'h1);
      ir_load(OP_PROGRAM);
      chk_word(64'(exp_q.size() + wr_q.size() + ctl_q.size()),
         64'h0);
      end_of_test();
   end
endmodule

// *** verilog/jtid_fifo.sv ***
// small first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ns
module jtid_fifo #(
   parameter int W = 64,
   parameter int DEPTH = 4
) (
   input wire logic clk, // clock
   input wire logic rst, // async reset, active high
   input wire logic in_valid, // writer offers a word
   output logic in_ready, // room for a word
   input wire logic [W-1:0] in_data, // word offered
   output logic out_valid, // a word is held
   input wire logic out_ready, // reader takes the word
   output logic [W-1:0] out_data // oldest word
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic not_full;
   } jtid_fifo_type;

   jtid_fifo_type q;
   jtid_fifo_type d;
   logic push;
   logic pop;

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
         $error("jtid_fifo depth must be a power of two, two or more");
      end
   endgenerate

   always_comb begin
      d = q;
      push = in_valid & q.not_full;
      pop = out_ready & (q.cnt != '0);
      if (push) begin
         d.mem[q.wp] = in_data;
         d.wp = q.wp + 1'b1;
      end
      if (pop) begin
         d.rp = q.rp + 1'b1;
      end
      d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
      // ready is a flop so the writer never sees a combinational path
      d.not_full = (d.cnt != FULL_CNT);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
         q.not_full <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign in_ready = q.not_full;
   assign out_valid = (q.cnt != '0);
   assign out_data = q.mem[q.rp];
endmodule

// *** verilog/jtid_pkg.sv ***
// package: opcodes, tap states, field layouts and carriers of the test port
package jtid_pkg;
   localparam int IR_W = 6;
   localparam int ID_W = 32;
   localparam int UCODE_W = 32;
   localparam int CFG_W = 64;
   localparam int STATUS_W = 4;
   localparam int CELLS_PER_IO = 3;
   localparam int CELL_OE = 0;
   localparam int CELL_OUT = 1;
   localparam int CELL_IN = 2;
   localparam int TLR_TMS_EDGES = 5;
   localparam int ID_REV_W = 4;
   localparam int ID_FAMILY_W = 7;
   localparam int ID_SIZE_W = 9;
   localparam int ID_COMPANY_W = 11;
   localparam int FIFO_DEPTH_RESET = 4;
   localparam logic [1:0] IR_CAP_LOW = 2'h1;
   localparam logic ID_LSB = 1'h1;

   localparam logic [IR_W-1:0] OP_EXTEST = 6'h00;
   localparam logic [IR_W-1:0] OP_SAMPLE = 6'h01;
   localparam logic [IR_W-1:0] OP_USER_ONE = 6'h02;
   localparam logic [IR_W-1:0] OP_USER_TWO = 6'h03;
   localparam logic [IR_W-1:0] OP_CFG_OUT = 6'h04;
   localparam logic [IR_W-1:0] OP_CFG_IN = 6'h05;
   localparam logic [IR_W-1:0] OP_INTEST = 6'h07;
   localparam logic [IR_W-1:0] OP_USERCODE = 6'h08;
   localparam logic [IR_W-1:0] OP_IDCODE = 6'h09;
   localparam logic [IR_W-1:0] OP_HIGHZ = 6'h0a;
   localparam logic [IR_W-1:0] OP_PROGRAM = 6'h0b;
   localparam logic [IR_W-1:0] OP_STARTUP = 6'h0c;
   localparam logic [IR_W-1:0] OP_SHUTDOWN = 6'h0d;
   localparam logic [IR_W-1:0] OP_BYPASS = 6'h3f;
   localparam logic [IR_W-1:0] IR_RESET_VALUE = OP_IDCODE;

   typedef enum logic [15:0] {
      TAP_RESET  = 16'h0001,
      TAP_IDLE   = 16'h0002,
      TAP_SEL_DR = 16'h0004,
      TAP_CAP_DR = 16'h0008,
      TAP_SH_DR  = 16'h0010,
      TAP_EX1_DR = 16'h0020,
      TAP_PA_DR  = 16'h0040,
      TAP_EX2_DR = 16'h0080,
      TAP_UPD_DR = 16'h0100,
      TAP_SEL_IR = 16'h0200,
      TAP_CAP_IR = 16'h0400,
      TAP_SH_IR  = 16'h0800,
      TAP_EX1_IR = 16'h1000,
      TAP_PA_IR  = 16'h2000,
      TAP_EX2_IR = 16'h4000,
      TAP_UPD_IR = 16'h8000
   } jtid_tap_type;

   typedef enum logic [6:0] {
      DR_BYPASS   = 7'h01,
      DR_BOUNDARY = 7'h02,
      DR_IDENT    = 7'h04,
      DR_USERCODE = 7'h08,
      DR_CONFIG   = 7'h10,
      DR_USER_ONE = 7'h20,
      DR_USER_TWO = 7'h40
   } jtid_dr_type;

   typedef struct packed {
      logic sel_one;
      logic sel_two;
      logic capture;
      logic shift;
      logic update;
      logic reset;
      logic tdi;
   } jtid_user_type;

   typedef struct packed {
      logic startup_pulse;
      logic shutdown_pulse;
      logic program_restart;
   } jtid_ctl_type;
endpackage

// *** verilog/jtid_sync.sv ***
// two-stage synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ns
module jtid_sync #(
   parameter int W = 1
) (
   input wire logic clk, // sampling clock
   input wire logic rst, // async reset, active high
   input wire logic [W-1:0] din, // asynchronous levels
   output logic [W-1:0] dout // levels in clk domain
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } jtid_sync_type;

   jtid_sync_type q;
   jtid_sync_type d;

   generate
      if (W < 1) begin : g_chk
         $error("jtid_sync width must be at least one");
      end
   endgenerate

   always_comb begin
      d.s1 = din;
      d.s2 = q.s1;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign dout = q.s2;
endmodule

// *** verilog/jtid_tap_top.sv ***
// test access port: tap controller, instruction decode, data registers
`timescale 1ns/1ns
module jtid_tap_top import jtid_pkg::*; #(
   parameter int NUM_IO = 4,
   parameter int NUM_IN = 2,
   parameter int FIFO_DEPTH = FIFO_DEPTH_RESET,
   // identity fields below are arbitrary neutral values
   parameter logic [ID_REV_W-1:0] ID_REVISION = 4'h1,
   parameter logic [ID_FAMILY_W-1:0] ID_FAMILY = 7'h2a,
   parameter logic [ID_SIZE_W-1:0] ID_SIZE = 9'h033,
   parameter logic [ID_COMPANY_W-1:0] ID_COMPANY = 11'h155
) (
   input wire logic core_clk, // 250 MHz sampling clock
   input wire logic rst, // async reset, active high
   input wire logic tck, // test clock pin
   input wire logic tms, // test mode select pin
   input wire logic tdi, // test data in pin
   output logic tdo, // test data out
   output logic tdo_oe, // high while tdo is driven
   input wire logic [NUM_IO-1:0] pad_in, // bidirectional pad levels
   output logic [NUM_IO-1:0] pad_out, // pad output value
   output logic [NUM_IO-1:0] pad_oe, // pad output enable
   input wire logic [NUM_IN-1:0] only_in, // input-only pad levels
   input wire logic [NUM_IO-1:0] core_out, // fabric output values
   input wire logic [NUM_IO-1:0] core_oe, // fabric output enables
   output logic [NUM_IO+NUM_IN-1:0] core_in, // pad values to fabric
   input wire logic config_done, // configuration finished
   input wire logic startup_clock_select, // startup clock is tck
   input wire logic [STATUS_W-1:0] device_status, // captured into ir
   input wire logic [UCODE_W-1:0] usercode, // code from bitstream
   output jtid_user_type user, // user register strobes
   input wire logic user_tdo_one, // user register one serial out
   input wire logic user_tdo_two, // user register two serial out
   output jtid_ctl_type ctl, // sequencer and restart pulses
   output logic cfg_wr_valid, // configuration word written
   output logic [CFG_W-1:0] cfg_wr_data, // configuration word
   input wire logic cfg_rd_valid, // readback word offered
   output logic cfg_rd_ready, // readback buffer has room
   input wire logic [CFG_W-1:0] cfg_rd_data // readback word
);
   localparam int BSR_W = NUM_IO * CELLS_PER_IO + NUM_IN;
   localparam int CORE_W = NUM_IO + NUM_IN;
   localparam int SYNC_W = 3 + NUM_IO + NUM_IN;
   localparam logic [ID_W-1:0] ID_VALUE =
      {ID_REVISION, ID_FAMILY, ID_SIZE, ID_COMPANY, ID_LSB};

   typedef struct packed {
      logic tck_prev;
      jtid_tap_type tap;
      logic [IR_W-1:0] ir_sh;
      logic [IR_W-1:0] ir;
      logic byp;
      logic [ID_W-1:0] id_sh;
      logic [CFG_W-1:0] cfg_sh;
      logic [BSR_W-1:0] bsr_sh;
      logic [BSR_W-1:0] bsr_upd;
      logic tdo;
      logic tdo_oe;
      logic cfg_wr_valid;
      logic [CFG_W-1:0] cfg_wr_data;
      logic [NUM_IO-1:0] pad_out;
      logic [NUM_IO-1:0] pad_oe;
      logic [CORE_W-1:0] core_in;
      jtid_user_type user;
      jtid_ctl_type ctl;
   } jtid_state_type;

   jtid_state_type q;
   jtid_state_type d;
   logic [SYNC_W-1:0] sync_out;
   logic tck_s;
   logic tms_s;
   logic tdi_s;
   logic [NUM_IO-1:0] pad_s;
   logic [NUM_IN-1:0] only_s;
   logic rise;
   logic fall;
   jtid_dr_type sel;
   logic extest;
   logic intest;
   logic highz;
   logic [BSR_W-1:0] bsr_cap;
   logic [NUM_IO-1:0] pad_out_n;
   logic [NUM_IO-1:0] pad_oe_n;
   logic [CORE_W-1:0] core_in_n;
   logic fifo_valid;
   logic fifo_pop;
   logic [CFG_W-1:0] fifo_data;
   logic [2:0] tms_high_q;

   generate
      if (NUM_IO < 1 || NUM_IN < 1 || FIFO_DEPTH < 2) begin : g_chk
         $error("jtid_tap_top needs a pad of each kind and a fifo");
      end
   endgenerate

   // every pin is asynchronous to core_clk, tck included
   jtid_sync #(.W(SYNC_W)) u_sync (
      .clk(core_clk),
      .rst(rst),
      .din({tck, tms, tdi, pad_in, only_in}),
      .dout(sync_out)
   );

   assign {tck_s, tms_s, tdi_s, pad_s, only_s} = sync_out;
   assign rise = tck_s & ~q.tck_prev;
   assign fall = ~tck_s & q.tck_prev;

   jtid_fifo #(.W(CFG_W), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
      .clk(core_clk),
      .rst(rst),
      .in_valid(cfg_rd_valid),
      .in_ready(cfg_rd_ready),
      .in_data(cfg_rd_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   function automatic jtid_tap_type next_tap(input jtid_tap_type s,
                                             input logic m);
      jtid_tap_type n;
      n = s;
      unique case (s)
         TAP_RESET: n = m ? TAP_RESET : TAP_IDLE;
         TAP_IDLE: n = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: n = m ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: n = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR: n = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: n = m ? TAP_UPD_DR : TAP_PA_DR;
         TAP_PA_DR: n = m ? TAP_EX2_DR : TAP_PA_DR;
         TAP_EX2_DR: n = m ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: n = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: n = m ? TAP_RESET : TAP_CAP_IR;
         TAP_CAP_IR: n = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR: n = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: n = m ? TAP_UPD_IR : TAP_PA_IR;
         TAP_PA_IR: n = m ? TAP_EX2_IR : TAP_PA_IR;
         TAP_EX2_IR: n = m ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: n = m ? TAP_SEL_DR : TAP_IDLE;
      endcase
      return n;
   endfunction

   // mode pins are not an input here: the port never defers to them
   function automatic jtid_dr_type decode_dr(input logic [IR_W-1:0] op,
                                             input logic done);
      jtid_dr_type r;
      r = DR_BYPASS;
      unique case (op)
         OP_EXTEST, OP_SAMPLE, OP_INTEST: r = DR_BOUNDARY;
         OP_USER_ONE: r = done ? DR_USER_ONE : r;
         OP_USER_TWO: r = done ? DR_USER_TWO : r;
         OP_CFG_OUT, OP_CFG_IN: r = DR_CONFIG;
         OP_USERCODE: r = DR_USERCODE;
         OP_IDCODE: r = DR_IDENT;
         OP_HIGHZ, OP_BYPASS: r = DR_BYPASS;
         OP_STARTUP, OP_SHUTDOWN, OP_PROGRAM: r = DR_BYPASS;
         default: r = DR_BYPASS;
      endcase
      return r;
   endfunction

   assign sel = decode_dr(q.ir, config_done);
   assign extest = (q.ir == OP_EXTEST);
   assign intest = (q.ir == OP_INTEST);
   assign highz = (q.ir == OP_HIGHZ);

   // enable cell sits lowest, nearest tdo; input-only pads sit past all
   genvar gi;
   generate
      for (gi = 0; gi < NUM_IO; gi++) begin : g_io
         assign bsr_cap[gi*CELLS_PER_IO+CELL_IN] = pad_s[gi];
         assign bsr_cap[gi*CELLS_PER_IO+CELL_OUT] = core_out[gi];
         assign bsr_cap[gi*CELLS_PER_IO+CELL_OE] = core_oe[gi];
         assign pad_out_n[gi] = extest ?
            q.bsr_upd[gi*CELLS_PER_IO+CELL_OUT] : core_out[gi];
         assign pad_oe_n[gi] = highz ? 1'b0 :
            extest ? q.bsr_upd[gi*CELLS_PER_IO+CELL_OE] : core_oe[gi];
         assign core_in_n[gi] = intest ?
            q.bsr_upd[gi*CELLS_PER_IO+CELL_IN] : pad_s[gi];
      end
      for (gi = 0; gi < NUM_IN; gi++) begin : g_in
         assign bsr_cap[NUM_IO*CELLS_PER_IO+gi] = only_s[gi];
         assign core_in_n[NUM_IO+gi] = intest ?
            q.bsr_upd[NUM_IO*CELLS_PER_IO+gi] : only_s[gi];
      end
   endgenerate

   always_comb begin
      d = q;
      fifo_pop = 1'b0;
      d.tck_prev = tck_s;
      d.cfg_wr_valid = 1'b0;
      d.ctl = '0;
      if (rise) begin
         d.tap = next_tap(q.tap, tms_s);
         if (q.tap == TAP_CAP_IR) begin
            d.ir_sh = {device_status, IR_CAP_LOW};
         end else if (q.tap == TAP_SH_IR) begin
            d.ir_sh = {tdi_s, q.ir_sh[IR_W-1:1]};
         end else if (q.tap == TAP_CAP_DR) begin
            unique case (sel)
               DR_BYPASS: d.byp = 1'b0;
               DR_BOUNDARY: d.bsr_sh = bsr_cap;
               DR_IDENT: d.id_sh = ID_VALUE;
               DR_USERCODE: d.id_sh = usercode;
               DR_CONFIG: begin
                  // readback words wait in the fifo until a capture under OP_CFG_OUT
                  fifo_pop = (q.ir == OP_CFG_OUT) & fifo_valid;
                  d.cfg_sh = fifo_pop ? fifo_data : '0;
               end
               DR_USER_ONE, DR_USER_TWO: ;
            endcase
         end else if (q.tap == TAP_SH_DR) begin
            unique case (sel)
               DR_BYPASS: d.byp = tdi_s;
               DR_BOUNDARY: d.bsr_sh = {tdi_s, q.bsr_sh[BSR_W-1:1]};
               DR_IDENT, DR_USERCODE: d.id_sh = {tdi_s, q.id_sh[ID_W-1:1]};
               DR_CONFIG: d.cfg_sh = {tdi_s, q.cfg_sh[CFG_W-1:1]};
               DR_USER_ONE, DR_USER_TWO: ;
            endcase
         end else if (q.tap == TAP_IDLE) begin
            // sequencer ticks only when tck is its chosen clock
            d.ctl.startup_pulse = (q.ir == OP_STARTUP) &
               startup_clock_select;
            d.ctl.shutdown_pulse = (q.ir == OP_SHUTDOWN) &
               startup_clock_select;
         end
      end
      if (fall) begin
         d.tdo_oe = (q.tap == TAP_SH_IR) | (q.tap == TAP_SH_DR);
         if (q.tap == TAP_SH_IR) begin
            d.tdo = q.ir_sh[0];
         end else if (q.tap == TAP_SH_DR) begin
            unique case (sel)
               DR_BYPASS: d.tdo = q.byp;
               DR_BOUNDARY: d.tdo = q.bsr_sh[0];
               DR_IDENT, DR_USERCODE: d.tdo = q.id_sh[0];
               DR_CONFIG: d.tdo = q.cfg_sh[0];
               DR_USER_ONE: d.tdo = user_tdo_one;
               DR_USER_TWO: d.tdo = user_tdo_two;
            endcase
         end
         if (q.tap == TAP_UPD_IR) begin
            d.ir = q.ir_sh;
            d.ctl.program_restart = (q.ir_sh == OP_PROGRAM);
         end
         if (q.tap == TAP_UPD_DR && sel == DR_BOUNDARY) begin
            d.bsr_upd = q.bsr_sh;
         end
         if (q.tap == TAP_UPD_DR && q.ir == OP_CFG_IN) begin
            d.cfg_wr_valid = 1'b1;
            d.cfg_wr_data = q.cfg_sh;
         end
      end
      if (q.tap == TAP_RESET) begin
         d.ir = IR_RESET_VALUE;
      end
      d.pad_out = pad_out_n;
      d.pad_oe = pad_oe_n;
      d.core_in = core_in_n;
      d.user.sel_one = (sel == DR_USER_ONE);
      d.user.sel_two = (sel == DR_USER_TWO);
      d.user.capture = (d.tap == TAP_CAP_DR);
      d.user.shift = (d.tap == TAP_SH_DR);
      d.user.update = (d.tap == TAP_UPD_DR);
      d.user.reset = (d.tap == TAP_RESET);
      d.user.tdi = tdi_s;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
         q.tap <= TAP_RESET;
         q.ir <= IR_RESET_VALUE;
      end else begin
         q <= d;
      end
   end

   assign tdo = q.tdo;
   assign tdo_oe = q.tdo_oe;
   assign pad_out = q.pad_out;
   assign pad_oe = q.pad_oe;
   assign core_in = q.core_in;
   assign user = q.user;
   assign ctl = q.ctl;
   assign cfg_wr_valid = q.cfg_wr_valid;
   assign cfg_wr_data = q.cfg_wr_data;

   // counts tck rises with tms high, only for checking the reset walk
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tms_high_q <= 3'h0;
      end else if (rise) begin
         tms_high_q <= !tms_s ? 3'h0 :
            (tms_high_q == 3'(TLR_TMS_EDGES)) ? tms_high_q :
            tms_high_q + 3'h1;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   tlr_reach_a: assert property (
      tms_high_q == 3'(TLR_TMS_EDGES) |-> q.tap == TAP_RESET)
      else $error("five tms-high edges missed reset");
   tdo_drive_a: assert property (fall &&
      (q.tap == TAP_SH_DR || q.tap == TAP_SH_IR) |=> q.tdo_oe)
      else $error("tdo not driven while shifting");
   tdo_float_a: assert property (fall &&
      !(q.tap == TAP_SH_DR || q.tap == TAP_SH_IR) |=> !q.tdo_oe)
      else $error("tdo driven outside shifting");
   tdo_edge_a: assert property ($changed(q.tdo) |->
      $past(fall)) else $error("tdo moved off a falling tck edge");
   ir_status_a: assert property (rise && q.tap == TAP_CAP_IR |=>
      q.ir_sh == {$past(device_status), IR_CAP_LOW})
      else $error("instruction capture lost status bits");
   byp_zero_a: assert property (rise && q.tap == TAP_CAP_DR &&
      sel == DR_BYPASS |=> !q.byp) else $error("bypass capture not zero");
   upd_hold_a: assert property (q.tap == TAP_SH_DR ##1
      q.tap == TAP_SH_DR |-> $stable(q.bsr_upd))
      else $error("update latch moved while shifting");
   highz_float_a: assert property (highz && $past(highz) |->
      q.pad_oe == '0) else $error("pads driven under high-z");
   prog_pulse_a: assert property (fall && q.tap == TAP_UPD_IR &&
      q.ir_sh == OP_PROGRAM |=> q.ctl.program_restart ##1
      !q.ctl.program_restart) else $error("program restart not one pulse");
   user_lock_a: assert property (!config_done &&
      !$past(config_done) |-> !q.user.sel_one && !q.user.sel_two)
      else $error("user register selected before configuration");
   id_lsb_a: assert property (rise && q.tap == TAP_CAP_DR &&
      sel == DR_IDENT |=> q.id_sh[0] == ID_LSB)
      else $error("identity lsb not one");
endmodule
